// [hdl/port_pin_function_select.sv]
// pin function selector for ports b, c, d and e with wishbone registers
//
// What this block does
// RULE1: port b pin 1 mode bit at 1 drives address line 17, at 0 keeps gpio.
// RULE2: port b pin 0 mode bit resets to 0 for gpio, at 1 drives address 16.
// RULE3: port c direction is 16 read/write bits, all zero after reset.
// RULE4: port c function bit n at 1 makes pin n address output n.
// RULE5: rom-off mode forces address pins on c, b0, b1; single chip keeps gpio.
// RULE6: port d direction is 16 read/write bits, all zero after reset.
// RULE7: port d function bit n at 1 makes pin n bidirectional data line n.
// RULE8: rom-off mode forces port d data lines; single chip keeps gpio.
// RULE9: port e direction is 16 read/write bits, all zero after reset.
// RULE10: port e pin 15 field 10 gives dma 1 acknowledge, 00 gpio, else none.
// RULE11: port e pin 14 field 10 gives dma 0 ack, 11 address hold, 00 gpio.
// RULE12: single chip mode keeps port e pins 14 and 15 as gpio.
// RULE13: bits 14, 12, 10, 8 put e pins 7..4 on timer capture/compare pins.
// RULE14: e pin 3 field 01 gives timer 0 d, 10 dma 1 request ack if not single.
// RULE15: every register accepts 8, 16 and 32 bit accesses.
// RULE16: direction 1 drives a gpio pin out, 0 leaves it input.
// RULE17: reserved port e function bits read 0 and ignore writes.
`timescale 1ns/10ps
`default_nettype none
module port_pin_function_select (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // operating mode pins
    input wire logic rom_off_i,
    input wire logic single_chip_i,
    // pads
    input wire logic [pin_mux_pkg::NPIN-1:0] pin_i,
    output logic [pin_mux_pkg::NPIN-1:0] pin_o,
    output logic [pin_mux_pkg::NPIN-1:0] pin_oe_o,
    output logic [pin_mux_pkg::NPIN-1:0] pin_in_o,
    // gpio data from the port data registers
    input wire logic [pin_mux_pkg::NPIN-1:0] gpio_out_i,
    // external bus
    input wire logic [17:0] ext_addr_i,
    input wire logic [15:0] ext_data_i,
    input wire logic ext_data_oe_i,
    // dma and bus strobes
    input wire logic dma0_acknowledge_i,
    input wire logic dma1_acknowledge_i,
    input wire logic address_hold_strobe_i,
    input wire logic dma1_request_ack_i,
    // timer capture/compare, index 4..1 for e7..e4, 0 for e3
    input wire logic [4:0] capcmp_out_i,
    input wire logic [4:0] capcmp_oe_i
);
    import pin_mux_pkg::*;

    localparam int SW = NPIN + 2;

    mux_sync_if #(.W(SW)) lvl ();
    bus_state_e bus_st_ff;
    logic [RW-1:0] regs_ff [NREG];
    logic [31:0] dat_ff;
    logic [NREG-1:0] hit;
    logic stat_hit;
    logic [31:0] rd_val;
    logic wr_en;
    logic rom_s;
    logic single_s;
    logic rom_ext;
    logic [NPIN-1:0] ded_sel;
    logic [NPIN-1:0] ded_out;
    logic [NPIN-1:0] ded_oe;
    logic [NPIN-1:0] dir_all;
    logic [31:0] cd_sel;
    logic [31:0] cd_out;
    logic [31:0] cd_oe;
    logic [1:0] pe15_code;
    logic [1:0] pe14_code;
    logic [1:0] pe3_code;

    // pads and mode straps are asynchronous, so they pass two flops
    assign lvl.raw = {single_chip_i, rom_off_i, pin_i};

    pin_level_sync #(.W(SW)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lvl(lvl.sync)
    );

    assign pin_in_o = lvl.synced[NPIN-1:0];
    assign rom_s = lvl.synced[NPIN];
    assign single_s = lvl.synced[NPIN+1];
    // single chip wins if both straps are set
    assign rom_ext = rom_s & ~single_s;

    // address decode against word indexes
    always_comb
    begin
        hit = '0;
        for (int k = 0; k < NREG; k++)
        begin
            hit[k] = wb_adr_i[31:2] == REG_INDEX[k][29:0];
        end
        stat_hit = wb_adr_i[31:2] == IDX_MODE_STAT[29:0];
    end

    // read mux; unmapped words read zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        for (int k = 0; k < NREG; k++)
        begin
            if (hit[k])
            begin
                rd_val = {16'h0000, regs_ff[k]};
            end
        end
        if (stat_hit)
        begin
            rd_val = {30'h0000_0000, single_s, rom_s};
        end
    end

    // one-hot bus sequencer: ack one cycle after the request, then drop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_st_ff <= BUS_IDLE;
        end
        else
        begin
            case (bus_st_ff)
                BUS_IDLE:
                begin
                    if (wb_cyc_i && wb_stb_i)
                    begin
                        bus_st_ff <= BUS_ACK;
                    end
                end
                BUS_ACK:
                begin
                    bus_st_ff <= BUS_IDLE;
                end
                default:
                begin
                    bus_st_ff <= BUS_IDLE;
                end
            endcase
        end
    end

    assign wb_ack_o = bus_st_ff[1];
    assign wr_en = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;

    // read data captured while idle, presented with ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_ff <= 32'h0000_0000;
        end
        else if (bus_st_ff == BUS_IDLE)
        begin
            dat_ff <= rd_val;
        end
    end

    assign wb_dat_o = dat_ff;

    // register file; byte lanes 0 and 1 carry the 16-bit register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int k = 0; k < NREG; k++)
            begin
                regs_ff[k] <= REG_RESET; // RULE3 RULE6 RULE9
            end
        end
        else if (wr_en)
        begin
            for (int k = 0; k < NREG; k++)
            begin
                if (hit[k])
                begin
                    // masked lanes keep old value; reserved bits stay 0
                    regs_ff[k] <= (regs_ff[k] & ~({{8{wb_sel_i[1]}},
                        {8{wb_sel_i[0]}}} & REG_WMASK[k])) |
                        (wb_dat_i[RW-1:0] & {{8{wb_sel_i[1]}},
                        {8{wb_sel_i[0]}}} & REG_WMASK[k]); // RULE15 RULE17
                end
            end
        end
    end

    // ports c and d: address and data lines, mode override per pin
    for (genvar g = 0; g < 16; g++)
    begin : g_cd
        assign cd_sel[g] = rom_ext |
            (regs_ff[R_PC_FUNC][g] & ~single_s); // RULE4 RULE5
        assign cd_out[g] = ext_addr_i[g];
        assign cd_oe[g] = 1'b1;
        assign cd_sel[16+g] = rom_ext |
            (regs_ff[R_PD_FUNC][g] & ~single_s); // RULE7 RULE8
        assign cd_out[16+g] = ext_data_i[g];
        assign cd_oe[16+g] = ext_data_oe_i;
    end

    assign pe15_code = regs_ff[R_PE_FUNC1][PE15_LSB+1:PE15_LSB];
    assign pe14_code = regs_ff[R_PE_FUNC1][PE14_LSB+1:PE14_LSB];
    assign pe3_code = regs_ff[R_PE_FUNC2][PE3_LSB+1:PE3_LSB];

    // dedicated function per pin; reserved codes fall back to gpio
    always_comb
    begin
        ded_sel = '0;
        ded_out = '0;
        ded_oe = '0;
        ded_sel[31:0] = cd_sel;
        ded_out[31:0] = cd_out;
        ded_oe[31:0] = cd_oe;
        // port b address lines 16 and 17
        ded_sel[PB0_PIN] = rom_ext |
            (regs_ff[R_PB_FUNC][PB0_BIT] & ~single_s); // RULE2 RULE5
        ded_out[PB0_PIN] = ext_addr_i[16];
        ded_oe[PB0_PIN] = 1'b1;
        ded_sel[PB1_PIN] = rom_ext |
            (regs_ff[R_PB_FUNC][PB1_BIT] & ~single_s); // RULE1 RULE5
        ded_out[PB1_PIN] = ext_addr_i[17];
        ded_oe[PB1_PIN] = 1'b1;
        // e15: dma 1 acknowledge, not in single chip
        if (pe15_code == CODE_DMA_ACK && !single_s) // RULE10 RULE12
        begin
            ded_sel[PE_BASE+15] = 1'b1;
            ded_out[PE_BASE+15] = dma1_acknowledge_i;
            ded_oe[PE_BASE+15] = 1'b1;
        end
        // e14: dma 0 acknowledge or address hold
        if (!single_s) // RULE12
        begin
            if (pe14_code == CODE_DMA_ACK) // RULE11
            begin
                ded_sel[PE_BASE+14] = 1'b1;
                ded_out[PE_BASE+14] = dma0_acknowledge_i;
                ded_oe[PE_BASE+14] = 1'b1;
            end
            else if (pe14_code == CODE_ADDR_HOLD) // RULE11
            begin
                ded_sel[PE_BASE+14] = 1'b1;
                ded_out[PE_BASE+14] = address_hold_strobe_i;
                ded_oe[PE_BASE+14] = 1'b1;
            end
        end
        // e7..e4: single bits at 14, 12, 10, 8
        for (int t = 0; t < 4; t++)
        begin
            if (regs_ff[R_PE_FUNC2][PE7_BIT-2*t]) // RULE13
            begin
                ded_sel[PE_BASE+7-t] = 1'b1;
                ded_out[PE_BASE+7-t] = capcmp_out_i[4-t];
                ded_oe[PE_BASE+7-t] = capcmp_oe_i[4-t];
            end
        end
        // e3: timer 0 d in every mode, request ack outside single chip
        if (pe3_code == CODE_TIMER_D) // RULE14
        begin
            ded_sel[PE_BASE+3] = 1'b1;
            ded_out[PE_BASE+3] = capcmp_out_i[0];
            ded_oe[PE_BASE+3] = capcmp_oe_i[0];
        end
        else if (pe3_code == CODE_REQ_ACK && !single_s) // RULE14
        begin
            ded_sel[PE_BASE+3] = 1'b1;
            ded_out[PE_BASE+3] = dma1_request_ack_i;
            ded_oe[PE_BASE+3] = 1'b1;
        end
    end

    // port b pins 0/1 have no direction register here: input only as gpio
    assign dir_all = {2'h0, regs_ff[R_PE_DIR], regs_ff[R_PD_DIR],
        regs_ff[R_PC_DIR]};

    // registered pad drivers, one cycle behind the selection
    for (genvar p = 0; p < NPIN; p++)
    begin : g_pad
        logic o_ff;
        logic oe_ff;
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                o_ff <= 1'b0;
                oe_ff <= 1'b0;
            end
            else
            begin
                o_ff <= ded_sel[p] ? ded_out[p] : gpio_out_i[p];
                oe_ff <= ded_sel[p] ? ded_oe[p] : dir_all[p]; // RULE16
            end
        end
        assign pin_o[p] = o_ff;
        assign pin_oe_o[p] = oe_ff;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) // RULE15
        else $error("ack held longer than one cycle");

    ack_after_req_a: assert property (
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) // RULE15
        else $error("request not acknowledged next cycle");

    lane_write_a: assert property ( // RULE15
        (wr_en && hit[R_PC_DIR] && wb_sel_i == 4'h1) |=>
        regs_ff[R_PC_DIR] == {$past(regs_ff[R_PC_DIR][15:8]),
        $past(wb_dat_i[7:0])})
        else $error("byte write to port c direction wrong");

    reset_clear_a: assert property (disable iff (1'b0) // RULE3
        rst_i |=> (regs_ff[R_PC_DIR] == 16'h0000 &&
        regs_ff[R_PD_DIR] == 16'h0000 && regs_ff[R_PE_DIR] == 16'h0000))
        else $error("direction registers not cleared by reset");

    reserved_zero_a: assert property ( // RULE17
        (regs_ff[R_PE_FUNC1] & 16'h0fff) == 16'h0000 &&
        (regs_ff[R_PE_FUNC2] & 16'haa00) == 16'h0000)
        else $error("reserved port e bit set");

    rom_off_addr_a: assert property ( // RULE5
        rom_ext |=> (pin_oe_o[15:0] == 16'hffff && pin_oe_o[PB0_PIN] &&
        pin_o[15:0] == $past(ext_addr_i[15:0])))
        else $error("address pins not forced in rom-off mode");

    single_gpio_a: assert property (single_s |=> // RULE5 RULE8 RULE16
        pin_oe_o[31:0] == $past({regs_ff[R_PD_DIR], regs_ff[R_PC_DIR]}))
        else $error("single chip pins not following direction");

    data_lines_a: assert property ( // RULE7 RULE8
        (rom_ext ##1 rom_ext) |-> (pin_o[31:16] == $past(ext_data_i) &&
        pin_oe_o[16] == $past(ext_data_oe_i)))
        else $error("port d data lines wrong");

    dma1_ack_a: assert property ( // RULE10
        (pe15_code == CODE_DMA_ACK && !single_s) |=>
        pin_o[PE_BASE+15] == $past(dma1_acknowledge_i))
        else $error("dma 1 acknowledge not on port e pin 15");

    addr_hold_a: assert property ( // RULE11
        (pe14_code == CODE_ADDR_HOLD && !single_s) |=>
        pin_o[PE_BASE+14] == $past(address_hold_strobe_i))
        else $error("address hold not on port e pin 14");

    e14_single_a: assert property (single_s |=> // RULE12
        pin_oe_o[PE_BASE+14] == $past(regs_ff[R_PE_DIR][14]))
        else $error("port e pin 14 not gpio in single chip");

    timer_pin_a: assert property ( // RULE13
        regs_ff[R_PE_FUNC2][PE7_BIT] |=>
        pin_o[PE_BASE+7] == $past(capcmp_out_i[4]))
        else $error("timer 2 b not on port e pin 7");

    e3_select_a: assert property ( // RULE14
        (pe3_code == CODE_REQ_ACK && single_s) |=>
        pin_o[PE_BASE+3] == $past(gpio_out_i[PE_BASE+3]))
        else $error("request ack on port e pin 3 in single chip");
endmodule : port_pin_function_select
`default_nettype wire

// [hdl/pin_mux_pkg.sv]
// constants, register map and state codes of the pin function selector
package pin_mux_pkg;
    // pin vector layout: port c, port d, port e, then port b pins 0 and 1
    localparam int NPIN = 50;
    localparam int PC_BASE = 0;
    localparam int PD_BASE = 16;
    localparam int PE_BASE = 32;
    localparam int PB0_PIN = 48;
    localparam int PB1_PIN = 49;
    localparam int NREG = 8;
    localparam int RW = 16;
    // register indexes; byte address is four times the index
    localparam logic [31:0] IDX_PC_DIR = 32'hffff8396;
    localparam logic [31:0] IDX_PC_FUNC = 32'hffff839c;
    localparam logic [31:0] IDX_PD_DIR = 32'hffff83a6;
    localparam logic [31:0] IDX_PD_FUNC = 32'hffff83ac;
    localparam logic [31:0] IDX_PE_DIR = 32'hffff83b4;
    localparam logic [31:0] IDX_PE_FUNC1 = 32'hffff83b8;
    localparam logic [31:0] IDX_PE_FUNC2 = 32'hffff83ba;
    localparam logic [31:0] IDX_PB_FUNC = 32'hffff839a;
    localparam logic [31:0] IDX_MODE_STAT = 32'hffff83be;
    // array slots of the register file
    localparam int R_PC_DIR = 0;
    localparam int R_PC_FUNC = 1;
    localparam int R_PD_DIR = 2;
    localparam int R_PD_FUNC = 3;
    localparam int R_PE_DIR = 4;
    localparam int R_PE_FUNC1 = 5;
    localparam int R_PE_FUNC2 = 6;
    localparam int R_PB_FUNC = 7;
    localparam logic [31:0] REG_INDEX [NREG] = '{IDX_PC_DIR, IDX_PC_FUNC,
        IDX_PD_DIR, IDX_PD_FUNC, IDX_PE_DIR, IDX_PE_FUNC1, IDX_PE_FUNC2,
        IDX_PB_FUNC};
    localparam logic [RW-1:0] REG_WMASK [NREG] = '{16'hffff, 16'hffff,
        16'hffff, 16'hffff, 16'hffff, 16'hf000, 16'h55ff, 16'h0005};
    localparam logic [RW-1:0] REG_RESET = 16'h0000;
    // field positions
    localparam int PB0_BIT = 0;
    localparam int PB1_BIT = 2;
    localparam int PE15_LSB = 14;
    localparam int PE14_LSB = 12;
    localparam int PE7_BIT = 14;
    localparam int PE3_LSB = 6;
    // field codes
    localparam logic [1:0] CODE_DMA_ACK = 2'h2;
    localparam logic [1:0] CODE_ADDR_HOLD = 2'h3;
    localparam logic [1:0] CODE_TIMER_D = 2'h1;
    localparam logic [1:0] CODE_REQ_ACK = 2'h2;
    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ACK = 2'h2
    } bus_state_e;
endpackage : pin_mux_pkg

// [hdl/mux_sync_if.sv]
// raw and synchronised pin and mode levels between the selector and syncer
`timescale 1ns/10ps
`default_nettype none
interface mux_sync_if #(parameter int W = 52);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport sync (input raw, output synced);
    modport core (output raw, input synced);
endinterface : mux_sync_if
`default_nettype wire

// [hdl/pin_level_sync.sv]
// two-stage synchroniser for asynchronous pin and mode levels
`timescale 1ns/10ps
`default_nettype none
module pin_level_sync #(
    parameter int W = 52
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // levels in and out
    mux_sync_if.sync lvl
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= lvl.raw;
            sync_ff <= meta_ff;
        end
    end

    assign lvl.synced = sync_ff;
endmodule : pin_level_sync
`default_nettype wire

// [tb/board_model.sv]
// board-side pad model: resolves each pad from device drive and board level
`timescale 1ns/10ps
`default_nettype none
module board_model (
    // device pad drive
    input wire logic [pin_mux_pkg::NPIN-1:0] pin_o_i,
    input wire logic [pin_mux_pkg::NPIN-1:0] pin_oe_i,
    // board levels for pads the device leaves alone
    input wire logic [pin_mux_pkg::NPIN-1:0] board_i,
    // resolved pad level
    output logic [pin_mux_pkg::NPIN-1:0] lvl_o
);
    import pin_mux_pkg::*;
    // an undriven pad shows the board's own level, so no stale value lingers
    assign lvl_o = (pin_o_i & pin_oe_i) | (board_i & ~pin_oe_i);
endmodule : board_model
`default_nettype wire

// [tb/port_pin_function_select_tb.sv]
// self-checking bench for the pin function selector
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        total_checks++; \
        if ((got) !== (ex)) \
            $display("ERROR %s exp %h got %h", nm, ex, got); \
        if ((got) !== (ex)) \
            err_count++; \
    end
module port_pin_function_select_tb;
    import pin_mux_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, rom, sc, dat_oe;
    logic [31:0] adr, wdat, dat_o;
    logic [3:0] sel, strobes;
    logic [NPIN-1:0] pin_i, pin_o, pin_oe, pin_in, gpio, board;
    logic [17:0] ext_addr;
    logic [15:0] ext_data;
    logic [4:0] cc_out, cc_oe;
    logic [RW-1:0] r [NREG];
    int err_count, total_checks;

    port_pin_function_select u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .rom_off_i(rom), .single_chip_i(sc), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe), .pin_in_o(pin_in), .gpio_out_i(gpio),
        .ext_addr_i(ext_addr), .ext_data_i(ext_data),
        .ext_data_oe_i(dat_oe), .dma0_acknowledge_i(strobes[0]),
        .dma1_acknowledge_i(strobes[1]), .address_hold_strobe_i(strobes[2]),
        .dma1_request_ack_i(strobes[3]), .capcmp_out_i(cc_out),
        .capcmp_oe_i(cc_oe));

    board_model u_board (.pin_o_i(pin_o), .pin_oe_i(pin_oe),
        .board_i(board), .lvl_o(pin_i));

    // 50 mhz system clock
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // one classic cycle; waits for ack, takes data at that edge only
    // no local limit: a slave that never answers is left to the watchdog
    task automatic wb_cycle(input logic w, input logic [31:0] idx,
        input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
        begin
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx[29:0], 2'b00};
        sel <= s;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
        begin
            @(posedge clk_i);
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
        end
    endtask : wb_cycle

    // pad levels worked out from the shadow registers and the straps
    function automatic void expect_pins(output logic [NPIN-1:0] eo,
        output logic [NPIN-1:0] ee);
        logic ad, ext;
        logic [1:0] c;
        ext = !sc;
        eo = gpio;
        ee = '0;
        for (int n = 0; n < 16; n++)
        begin
            ad = ext && (rom || r[R_PC_FUNC][n]);
            ee[PC_BASE+n] = ad ? 1'b1 : r[R_PC_DIR][n];
            eo[PC_BASE+n] = ad ? ext_addr[n] : gpio[PC_BASE+n];
            ad = ext && (rom || r[R_PD_FUNC][n]);
            ee[PD_BASE+n] = ad ? dat_oe : r[R_PD_DIR][n];
            eo[PD_BASE+n] = ad ? ext_data[n] : gpio[PD_BASE+n];
            ee[PE_BASE+n] = r[R_PE_DIR][n];
        end
        for (int b = 0; b < 2; b++)
        begin
            ad = ext && (rom || r[R_PB_FUNC][2*b]);
            ee[PB0_PIN+b] = ad;
            eo[PB0_PIN+b] = ad ? ext_addr[16+b] : gpio[PB0_PIN+b];
        end
        // timer pins e4..e7 stay available in every mode
        for (int t = 1; t < 5; t++)
            if (r[R_PE_FUNC2][6+2*t])
                {ee[PE_BASE+3+t], eo[PE_BASE+3+t]} = {cc_oe[t], cc_out[t]};
        c = r[R_PE_FUNC1][15:14];
        if (ext && c == 2'h2)
            {ee[PE_BASE+15], eo[PE_BASE+15]} = {1'b1, strobes[1]};
        c = r[R_PE_FUNC1][13:12];
        if (ext && c == 2'h2)
            {ee[PE_BASE+14], eo[PE_BASE+14]} = {1'b1, strobes[0]};
        if (ext && c == 2'h3)
            {ee[PE_BASE+14], eo[PE_BASE+14]} = {1'b1, strobes[2]};
        c = r[R_PE_FUNC2][7:6];
        if (c == 2'h1)
            {ee[PE_BASE+3], eo[PE_BASE+3]} = {cc_oe[0], cc_out[0]};
        if (ext && c == 2'h2)
            {ee[PE_BASE+3], eo[PE_BASE+3]} = {1'b1, strobes[3]};
    endfunction : expect_pins

    // writes every shadow register, lets straps settle, judges the pads
    task automatic push_all;
        logic [31:0] q;
        logic [NPIN-1:0] eo, ee;
        begin
        for (int k = 0; k < NREG; k++)
            wb_cycle(1'b1, REG_INDEX[k], 4'h3, {16'h0, r[k]}, q);
        repeat (4) @(posedge clk_i);
        expect_pins(eo, ee);
        `CHK("pin_oe", ee, pin_oe)
        `CHK("pin_out", eo & ee, pin_o & ee)
        `CHK("pin_in", pin_i, pin_in)
        wb_cycle(1'b0, IDX_MODE_STAT, 4'hf, 32'h0, q);
        `CHK("mode", {30'h0, sc, rom}, q)
        end
    endtask : push_all

    // reset values, widths, reserved bits, byte lanes, unmapped place
    task automatic t_access;
        logic [31:0] q;
        logic [15:0] m [NREG] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff,
            16'hffff, 16'hf000, 16'h55ff, 16'h0005};
        begin
        for (int k = 0; k < NREG; k++)
        begin
            wb_cycle(1'b0, REG_INDEX[k], 4'hf, 32'h0, q);
            `CHK("reset", 32'h0, q)
            wb_cycle(1'b1, REG_INDEX[k], 4'hf, 32'hffffffff, q);
            wb_cycle(1'b0, REG_INDEX[k], 4'hf, 32'h0, q);
            `CHK("readback", {16'h0, m[k]}, q)
        end
        wb_cycle(1'b1, IDX_PC_DIR, 4'h1, 32'h0, q);
        wb_cycle(1'b1, IDX_PC_DIR, 4'h2, 32'h0000a500, q);
        wb_cycle(1'b0, IDX_PC_DIR, 4'h3, 32'h0, q);
        `CHK("byte_lane", 32'h0000a500, q)
        wb_cycle(1'b1, 32'hffff83c0, 4'hf, 32'hffffffff, q);
        wb_cycle(1'b0, 32'hffff83c0, 4'hf, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        end
    endtask : t_access

    // every code of the port e fields, with plain gpio around them
    task automatic t_codes;
        begin
        for (int c = 0; c < 4; c++)
        begin
            r = '{default: 16'h0};
            r[R_PE_DIR] = 16'hffff;
            r[R_PC_DIR] = 16'h3c3c;
            r[R_PE_FUNC1] = {2'(c), 2'(c), 12'hfff};
            r[R_PE_FUNC2] = {(c[0] ? 8'h50 : 8'h05), 2'(c), 6'h3f};
            strobes <= 4'(c) ^ 4'ha;
            cc_out <= 5'h15 ^ 5'(c);
            ext_data <= 16'h1234 << c;
            push_all();
        end
        end
    endtask : t_codes

    // strap combinations overriding the function bits
    task automatic t_modes;
        begin
        r = '{16'h0f0f, 16'h00ff, 16'hf00f, 16'hf0f0, 16'h0f0f, 16'ha000,
            16'h5580, 16'h0001};
        for (int m = 0; m < 4; m++)
        begin
            rom <= m[0];
            sc <= m[1];
            dat_oe <= m[0];
            ext_addr <= 18'h2a5c3 ^ 18'(m * 18'h11111);
            board <= ~board;
            push_all();
        end
        end
    endtask : t_modes

    // verdict and end of run
    task automatic summarize;
        begin
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
        end
    endtask : summarize

    // watchdog against a hung bus; the full run needs about 350 cycles
    initial
    begin
        repeat (2000) @(posedge clk_i);
        err_count++;
        summarize();
    end

    // main sequence
    initial
    begin
        {rst_i, cyc, stb, we, rom, sc, dat_oe} = 7'h40;
        {adr, wdat, sel, strobes, cc_out, cc_oe} = '0;
        {gpio, board} = {50'h2_5a5a_c3c3_9669, 50'h1_0ff0_a5a5_3cc3};
        {ext_addr, ext_data} = {18'h1beef, 16'h7e81};
        err_count = 0;
        total_checks = 0;
        r = '{default: 16'h0};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_access();
        cc_oe <= 5'h1b;
        t_codes();
        t_modes();
        summarize();
    end
endmodule : port_pin_function_select_tb
`default_nettype wire
